// file: tcp_pkg.sv
/*
 * shared constants for both ends of the transceiver control port:
 * register offsets, field positions, reset values, timing counts,
 * the host's own apb map and the host sequencer states.
 * assumes a 10 MHz system clock on both ends.
 */
package tcp_pkg;
	// ==========================================================
	// device register offsets (low byte; address bit 8 = link)
	localparam logic [7:0] OFF_SRST = 8'h04;
	localparam logic [7:0] OFF_LINK_SRC = 8'h09;
	localparam logic [7:0] OFF_TMR_EN = 8'h0A;
	localparam logic [7:0] OFF_TMR_FLAG = 8'h0B;
	localparam logic [7:0] OFF_LINE_STD = 8'h20;
	localparam logic [7:0] OFF_TX_CFG0 = 8'h22;
	localparam logic [7:0] OFF_RX_CFG0 = 8'h28;
	localparam logic [7:0] OFF_MOD_TWO = 8'h3F;
	localparam logic [7:0] OFF_MOD_ZERO = 8'h40;
	localparam logic [7:0] OFF_MOD_ONE = 8'h41;
	// indirect blocks: tx payload, rx payload, signaling buffer
	localparam logic [7:0] OFF_IND_STAT [3] = '{8'hC8, 8'hCD, 8'hD3};
	localparam logic [7:0] OFF_IND_CTRL [3] = '{8'hC9, 8'hCE, 8'hD4};
	localparam logic [7:0] OFF_IND_DATA [3] = '{8'hCA, 8'hCF, 8'hD5};
	// ==========================================================
	// fields and reset values
	localparam int BIT_PWR_OFF = 4;
	localparam int BIT_IND_DIR = 7;
	localparam int BIT_TMR = 0;
	localparam logic [7:0] RST_REG = 8'h00;
	// ==========================================================
	// timing
	localparam int CLK_NS = 100;
	localparam int POR_HOLD_MS = 10;
	localparam int HW_HOLD_NS = 100;
	localparam int ACCESS_WAIT_MS = 2;
	localparam int IND_DONE_US = 4;
	localparam int SEC_S = 1;
	localparam int POR_CYC = (POR_HOLD_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int HW_HOLD_CYC = (HW_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACCESS_WAIT_CYC =
		(ACCESS_WAIT_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int IND_CYC = IND_DONE_US * 1000 / CLK_NS;
	localparam int SEC_CYC = SEC_S * 1000000000 / CLK_NS;
	localparam int LINK_HALF_DEF = 8;
	// ==========================================================
	// host apb map
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_CFG = 8'h04;
	localparam logic [7:0] APB_STAT = 8'h08;
	localparam logic [7:0] APB_CTRL = 8'h0C;
	localparam int CMD_RD_BIT = 12;
	localparam int CMD_DATA_LSB = 16;
	localparam int CFG_SPI_BIT = 0;
	localparam int CFG_STYLE_BIT = 1;
	localparam int CTRL_HWRST_BIT = 0;
	typedef enum logic [5:0] {
		HS_RST = 6'h01,
		HS_WAIT = 6'h02,
		HS_IDLE = 6'h04,
		HS_LOAD = 6'h08,
		HS_SPI = 6'h10,
		HS_PAR = 6'h20
	} tcp_hst_t;
endpackage : tcp_pkg

// file: tcp_link_if.sv
/*
 * pins between host and device: reset, mode straps, serial port,
 * parallel bus and interrupt.
 * assumes the shared data bus floats high when nobody drives it.
 */
`timescale 1ns/1ps
interface tcp_link_if;
	logic rst_n;
	logic spi_sel;
	logic style_sel;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sdo;
	logic strb_a_n;
	logic strb_b;
	logic irq_n;
	logic [8:0] addr;
	logic [7:0] hd_o;
	logic hd_oe;
	logic [7:0] dd_o;
	logic dd_oe;
	logic [7:0] d;
	// pull-up when the bus is released
	assign d = hd_oe ? hd_o : (dd_oe ? dd_o : 8'hFF);
	modport host (output rst_n, spi_sel, style_sel, cs_n, sclk, sdi,
		strb_a_n, strb_b, addr, hd_o, hd_oe, input sdo, irq_n, d);
	modport dev (input rst_n, spi_sel, style_sel, cs_n, sclk, sdi,
		strb_a_n, strb_b, addr, d, output sdo, irq_n, dd_o, dd_oe);
endinterface : tcp_link_if

// file: tcp_dev_end.sv
/*
 * device end of the transceiver control port: serial and parallel
 * register port, resets, interrupt summary, one-second timer, path
 * power-down and the busy-polled indirect access blocks.
 * assumes function blocks deliver their module summary bits already
 * qualified by their own enables, and all link pins are asynchronous.
 */
`timescale 1ns/1ps
module tcp_dev_end
	import tcp_pkg::*;
#(
	parameter int SEC_CYCLES = SEC_CYC,
	parameter int IND_CYCLES = IND_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	tcp_link_if.dev lnk,
	input wire logic [47:0] mod_irq_i,
	input wire logic [1:0] rx_data_i,
	input wire logic [1:0] tx_data_i,
	output logic [1:0] rx_path_o,
	output logic [1:0] tx_path_o,
	output logic [1:0] tx_path_oe_o
);
	// ==========================================================
	// pin synchronisers
	localparam int NS = 25;
	wire [NS-1:0] pin_w;
	logic [NS-1:0] s1_r;
	logic [NS-1:0] s2_r;
	logic [NS-1:0] s3_r;
	assign pin_w = {lnk.rst_n, lnk.spi_sel, lnk.style_sel, lnk.cs_n,
		lnk.sclk, lnk.sdi, lnk.strb_a_n, lnk.strb_b, lnk.addr, lnk.d};
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s1_r <= '1;
			s2_r <= '1;
			s3_r <= '1;
		end else begin
			s1_r <= pin_w;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	wire hw_rst = rst_i | ~s2_r[24];
	wire spi_s = s2_r[23];
	wire sty_s = s2_r[22];
	wire cs_n_s = s2_r[21];
	wire sclk_s = s2_r[20];
	wire sdi_s = s2_r[19];
	wire sa_s = s2_r[18];
	wire sb_s = s2_r[17];
	wire [8:0] pa_s = s2_r[16:8];
	wire [7:0] pd_s = s2_r[7:0];
	wire cs_p = s3_r[21];
	wire sclk_p = s3_r[20];
	wire sa_p = s3_r[18];
	wire sb_p = s3_r[17];
	logic sw_rst_r;
	wire rst_any = hw_rst | sw_rst_r;

	// ==========================================================
	// serial port decode
	logic [4:0] bit_r;
	logic [23:0] sh_r;
	logic [7:0] so_r;
	logic sdo_r;
	logic spi_rd_r;
	logic [7:0] rd_data;
	wire cs_fall = ~cs_n_s & cs_p;
	wire sck_rise = spi_s & ~cs_n_s & sclk_s & ~sclk_p & (bit_r != 5'd24);
	wire sck_fall = spi_s & ~cs_n_s & ~sclk_s & sclk_p;
	wire [10:0] spi_addr_w = {sh_r[9:0], sdi_s};
	wire spi_rd_go = sck_rise & (bit_r == 5'd15) & sh_r[14];
	wire spi_wr_go = sck_rise & (bit_r == 5'd23) & ~sh_r[22];

	// parallel port decode: strobe a is data/read strobe, b is dir/write
	wire p_cs = ~spi_s & ~cs_n_s;
	wire p_rd_act = p_cs & ~sa_s & (sty_s | sb_s);
	wire p_rd_go = p_rd_act & sa_p;
	wire p_wr_go = p_cs & (sty_s ? (sb_s & ~sb_p) : (sa_s & ~sa_p & ~sb_s));

	wire wr_go = spi_wr_go | p_wr_go;
	wire rd_go = spi_rd_go | p_rd_go;
	wire [10:0] acc_addr = ~spi_s ? {2'b00, pa_s} :
		(spi_wr_go ? sh_r[17:7] : spi_addr_w);
	wire [7:0] acc_wdata = spi_s ? {sh_r[6:0], sdi_s} : pd_s;
	wire lk = acc_addr[8];
	wire [7:0] off = acc_addr[7:0];
	wire hit_lk = acc_addr[10:9] == 2'b00;
	wire glob = hit_lk & ~lk;

	always_ff @(posedge clk_sys_i) begin
		if (rst_any) begin
			bit_r <= 5'd0;
			sh_r <= 24'h000000;
			so_r <= 8'h00;
			sdo_r <= 1'b0;
			spi_rd_r <= 1'b0;
		end else if (cs_fall) begin
			bit_r <= 5'd0;
			spi_rd_r <= 1'b0;
		end else if (sck_rise) begin
			sh_r <= {sh_r[22:0], sdi_s};
			bit_r <= bit_r + 5'd1;
			if (spi_rd_go) begin
				so_r <= rd_data;
				spi_rd_r <= 1'b1;
			end
		end else if (sck_fall & spi_rd_r) begin
			sdo_r <= so_r[7];
			so_r <= {so_r[6:0], 1'b0};
		end
	end
	assign lnk.sdo = sdo_r;

	// ==========================================================
	// direct registers
	logic [1:0][7:0] line_r;
	logic [1:0][7:0] txc_r;
	logic [1:0][7:0] rxc_r;
	logic tmr_en_r;
	logic tmr_flag_r;
	logic [31:0] sec_r;
	wire wr_line = wr_go & hit_lk & (off == OFF_LINE_STD);
	wire wr_txc = wr_go & hit_lk & (off == OFF_TX_CFG0);
	wire wr_rxc = wr_go & hit_lk & (off == OFF_RX_CFG0);
	wire wr_tmr = wr_go & glob & (off == OFF_TMR_EN);
	wire rd_flag = rd_go & glob & (off == OFF_TMR_FLAG);
	wire sec_tick = sec_r == 32'(SEC_CYCLES - 1);

	always_ff @(posedge clk_sys_i) begin
		if (hw_rst) begin
			sw_rst_r <= 1'b0;
		end else begin
			sw_rst_r <= wr_go & glob & (off == OFF_SRST);
		end
	end
	// soft reset never reaches this one
	always_ff @(posedge clk_sys_i) begin
		if (hw_rst) begin
			line_r <= {2{RST_REG}};
		end else if (wr_line) begin
			line_r[lk] <= acc_wdata;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (rst_any) begin
			txc_r <= {2{RST_REG}};
			rxc_r <= {2{RST_REG}};
			tmr_en_r <= 1'b0;
			tmr_flag_r <= 1'b0;
			sec_r <= 32'h00000000;
		end else begin
			if (wr_txc) begin
				txc_r[lk] <= acc_wdata;
			end
			if (wr_rxc) begin
				rxc_r[lk] <= acc_wdata;
			end
			if (wr_tmr) begin
				tmr_en_r <= acc_wdata[BIT_TMR];
			end
			sec_r <= sec_tick ? 32'h00000000 : sec_r + 32'h00000001;
			// a tick in the reading cycle survives the read
			if (sec_tick) begin
				tmr_flag_r <= 1'b1;
			end else if (rd_flag) begin
				tmr_flag_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// indirect access blocks, three per link
	logic [5:0] ibusy_w;
	logic [5:0][7:0] ictl_w;
	logic [5:0][7:0] idat_w;
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_ind
			localparam int L = g / 3;
			localparam int B = g % 3;
			logic [7:0] mem [128];
			logic [7:0] ctl_r;
			logic [7:0] dat_r;
			logic busy_r;
			logic [15:0] cnt_r;
			wire sel = hit_lk & (lk == L[0]);
			wire wr_ctl = wr_go & sel & (off == OFF_IND_CTRL[B]);
			wire wr_dat = wr_go & sel & (off == OFF_IND_DATA[B]);
			wire last = busy_r & (cnt_r == 16'(IND_CYCLES - 1));
			always_ff @(posedge clk_sys_i) begin
				if (rst_any) begin
					ctl_r <= RST_REG;
					dat_r <= RST_REG;
					busy_r <= 1'b0;
					cnt_r <= 16'h0000;
				end else if (busy_r) begin
					cnt_r <= cnt_r + 16'h0001;
					if (last) begin
						busy_r <= 1'b0;
						if (ctl_r[BIT_IND_DIR]) begin
							dat_r <= mem[ctl_r[6:0]];
						end
					end
				end else if (wr_ctl) begin
					ctl_r <= acc_wdata;
					busy_r <= 1'b1;
					cnt_r <= 16'h0000;
				end else if (wr_dat) begin
					dat_r <= acc_wdata;
				end
			end
			always_ff @(posedge clk_sys_i) begin
				if (last & ~ctl_r[BIT_IND_DIR]) begin
					mem[ctl_r[6:0]] <= dat_r;
				end
			end
			assign ibusy_w[g] = busy_r;
			assign ictl_w[g] = ctl_r;
			assign idat_w[g] = dat_r;
		end
	endgenerate

	// ==========================================================
	// read mux and parallel data out
	wire [1:0] link_irq = {|mod_irq_i[47:24], |mod_irq_i[23:0]};
	wire [23:0] mod_w = lk ? mod_irq_i[47:24] : mod_irq_i[23:0];
	always_comb begin
		rd_data = 8'h00;
		if (hit_lk) begin
			case (off)
				OFF_LINK_SRC: rd_data = {6'h00, link_irq & {2{~lk}}};
				OFF_TMR_EN: rd_data = {7'h00, tmr_en_r & ~lk};
				OFF_TMR_FLAG: rd_data = {7'h00, tmr_flag_r & ~lk};
				OFF_LINE_STD: rd_data = line_r[lk];
				OFF_TX_CFG0: rd_data = txc_r[lk];
				OFF_RX_CFG0: rd_data = rxc_r[lk];
				OFF_MOD_ZERO: rd_data = mod_w[7:0];
				OFF_MOD_ONE: rd_data = mod_w[15:8];
				OFF_MOD_TWO: rd_data = mod_w[23:16];
				default: rd_data = 8'h00;
			endcase
			for (int b = 0; b < 3; b++) begin
				if (off == OFF_IND_STAT[b]) begin
					rd_data = {7'h00, ibusy_w[int'(lk) * 3 + b]};
				end
				if (off == OFF_IND_CTRL[b]) begin
					rd_data = ictl_w[int'(lk) * 3 + b];
				end
				if (off == OFF_IND_DATA[b]) begin
					rd_data = idat_w[int'(lk) * 3 + b];
				end
			end
		end
	end
	logic [7:0] dd_r;
	always_ff @(posedge clk_sys_i) begin
		if (rst_any) begin
			dd_r <= 8'h00;
		end else if (p_rd_go) begin
			// latched once: a clear-on-read flag must not reload as 0
			dd_r <= rd_data;
		end
	end
	assign lnk.dd_o = dd_r;
	assign lnk.dd_oe = p_rd_act;

	// ==========================================================
	// interrupt pin and path power-down
	logic irq_n_r;
	wire [1:0] rx_off = {rxc_r[1][BIT_PWR_OFF], rxc_r[0][BIT_PWR_OFF]};
	wire [1:0] tx_off = {txc_r[1][BIT_PWR_OFF], txc_r[0][BIT_PWR_OFF]};
	always_ff @(posedge clk_sys_i) begin
		if (rst_any) begin
			irq_n_r <= 1'b1;
			rx_path_o <= 2'b00;
			tx_path_o <= 2'b00;
			tx_path_oe_o <= 2'b00;
		end else begin
			// registered so the pin never glitches
			irq_n_r <= ~(|link_irq | (tmr_flag_r & tmr_en_r));
			rx_path_o <= rx_data_i & ~rx_off;
			tx_path_o <= tx_data_i & ~tx_off;
			tx_path_oe_o <= ~tx_off;
		end
	end
	assign lnk.irq_n = irq_n_r;
endmodule : tcp_dev_end

// file: tcp_host_end.sv
/*
 * host end of the transceiver control port: takes orders over apb,
 * drives the device reset and runs one serial or parallel register
 * transfer per command (plus a soft reset transfer after a line std write), with the waits the device needs.
 * assumes apb master on the same clock; link pins asynchronous.
 */
`timescale 1ns/1ps
module tcp_host_end
	import tcp_pkg::*;
#(
	parameter int RST_HOLD = POR_CYC,
	parameter int RUN_HOLD = HW_HOLD_CYC,
	parameter int ACC_WAIT = ACCESS_WAIT_CYC,
	parameter int HALF = LINK_HALF_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	tcp_link_if.host lnk
);
	// ==========================================================
	// apb slave
	tcp_hst_t st_r;
	logic [1:0] cfg_r;
	logic [7:0] rdat_r;
	logic [9:0] s1_r;
	logic [9:0] s2_r;
	wire idle = st_r == HS_IDLE;
	wire acc = psel_i & penable_i;
	wire hit_cmd = paddr_i == APB_CMD;
	wire hit_cfg = paddr_i == APB_CFG;
	wire hit_stat = paddr_i == APB_STAT;
	wire hit_ctrl = paddr_i == APB_CTRL;
	wire mapped = hit_cmd | hit_cfg | hit_stat | hit_ctrl;
	// commands outside idle are dropped: software polls busy first
	wire wr_cmd = acc & pwrite_i & hit_cmd & idle;
	wire wr_rst = acc & pwrite_i & hit_ctrl & idle &
		pwdata_i[CTRL_HWRST_BIT];
	wire irq_s = s2_r[8];
	wire [31:0] stat_w = {16'h0000, rdat_r, 6'h00, ~irq_s, ~idle};
	wire [31:0] rmux_w = hit_cfg ? {30'h00000000, cfg_r} :
		(hit_stat ? stat_w : 32'h00000000);
	assign pready_o = 1'b1;
	assign pslverr_o = acc & ~mapped;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cfg_r <= 2'b00;
			prdata_o <= 32'h00000000;
			s1_r <= '1;
			s2_r <= '1;
		end else begin
			s1_r <= {lnk.sdo, lnk.irq_n, lnk.d};
			s2_r <= s1_r;
			if (psel_i & ~penable_i) begin
				prdata_o <= rmux_w;
			end
			if (acc & pwrite_i & hit_cfg) begin
				cfg_r <= pwdata_i[1:0];
			end
		end
	end

	// ==========================================================
	// link sequencer
	logic [23:0] cnt_r;
	logic [23:0] lim_r;
	logic [5:0] ph_r;
	logic [10:0] addr_r;
	logic rd_r;
	logic [7:0] wd_r;
	logic [23:0] sh_r;
	logic [7:0] rx_r;
	logic pend_r;
	logic rst_n_r;
	logic cs_n_r;
	logic sclk_r;
	logic sdi_r;
	logic sa_r;
	logic sb_r;
	logic hoe_r;
	wire tick = cnt_r == 24'(HALF - 1);
	wire done = tick & (((st_r == HS_SPI) & (ph_r == 6'd47)) |
		((st_r == HS_PAR) & (ph_r == 6'd2)));
	wire is_line = (addr_r[10:9] == 2'b00) & (addr_r[7:0] == OFF_LINE_STD);
	wire is_srst = addr_r == {3'b000, OFF_SRST};
	wire sty = cfg_r[CFG_STYLE_BIT];

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_r <= HS_RST;
			cnt_r <= 24'h000000;
			lim_r <= 24'(RST_HOLD - 1);
			ph_r <= 6'd0;
			addr_r <= 11'h000;
			rd_r <= 1'b0;
			wd_r <= 8'h00;
			sh_r <= 24'h000000;
			rx_r <= 8'h00;
			rdat_r <= 8'h00;
			pend_r <= 1'b0;
			rst_n_r <= 1'b0;
			cs_n_r <= 1'b1;
			sclk_r <= 1'b0;
			sdi_r <= 1'b0;
			sa_r <= 1'b1;
			sb_r <= 1'b1;
			hoe_r <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 24'h000001;
			case (st_r)
				HS_RST: begin
					if (cnt_r == lim_r) begin
						rst_n_r <= 1'b1;
						lim_r <= 24'(ACC_WAIT - 1);
						cnt_r <= 24'h000000;
						st_r <= HS_WAIT;
					end
				end
				HS_WAIT: begin
					if (cnt_r == lim_r) begin
						st_r <= pend_r ? HS_LOAD : HS_IDLE;
						if (pend_r) begin
							addr_r <= {3'b000, OFF_SRST};
							rd_r <= 1'b0;
							pend_r <= 1'b0;
						end
					end
				end
				HS_IDLE: begin
					if (wr_rst) begin
						rst_n_r <= 1'b0;
						lim_r <= 24'(RUN_HOLD - 1);
						cnt_r <= 24'h000000;
						st_r <= HS_RST;
					end else if (wr_cmd) begin
						addr_r <= pwdata_i[10:0];
						rd_r <= pwdata_i[CMD_RD_BIT];
						wd_r <= pwdata_i[CMD_DATA_LSB +: 8];
						st_r <= HS_LOAD;
					end
				end
				HS_LOAD: begin
					cnt_r <= 24'h000000;
					ph_r <= 6'd0;
					cs_n_r <= 1'b0;
					if (cfg_r[CFG_SPI_BIT]) begin
						sh_r <= {rd_r, 4'h0, addr_r, wd_r};
						sdi_r <= rd_r;
						st_r <= HS_SPI;
					end else begin
						sb_r <= sty | rd_r;
						hoe_r <= ~rd_r;
						st_r <= HS_PAR;
					end
				end
				HS_SPI: begin
					if (tick) begin
						cnt_r <= 24'h000000;
						ph_r <= ph_r + 6'd1;
						sclk_r <= ~sclk_r;
						if (~sclk_r) begin
							rx_r <= {rx_r[6:0], s2_r[9]};
						end else begin
							sh_r <= {sh_r[22:0], 1'b0};
							sdi_r <= sh_r[22];
						end
					end
				end
				HS_PAR: begin
					if (tick) begin
						cnt_r <= 24'h000000;
						ph_r <= ph_r + 6'd1;
						if (ph_r == 6'd0) begin
							sa_r <= sty & ~rd_r;
							sb_r <= rd_r;
						end else if (ph_r == 6'd1) begin
							rx_r <= s2_r[7:0];
							sa_r <= 1'b1;
							sb_r <= sty | rd_r;
						end
					end
				end
				default: st_r <= HS_IDLE;
			endcase
			if (done) begin
				cs_n_r <= 1'b1;
				hoe_r <= 1'b0;
				sb_r <= 1'b1;
				// parallel bus is already released here: keep strobe sample
				if (rd_r) begin
					rdat_r <= rx_r;
				end
				// soft reset or plain gap before the next transfer
				lim_r <= (is_srst & ~rd_r) ? 24'(ACC_WAIT - 1) :
					24'(HALF - 1);
				pend_r <= is_line & ~rd_r;
				cnt_r <= 24'h000000;
				st_r <= HS_WAIT;
			end
		end
	end
	assign lnk.rst_n = rst_n_r;
	assign lnk.spi_sel = cfg_r[CFG_SPI_BIT];
	assign lnk.style_sel = sty;
	assign lnk.cs_n = cs_n_r;
	assign lnk.sclk = sclk_r;
	assign lnk.sdi = sdi_r;
	assign lnk.strb_a_n = sa_r;
	assign lnk.strb_b = sb_r;
	assign lnk.addr = addr_r[8:0];
	assign lnk.hd_o = wd_r;
	assign lnk.hd_oe = hoe_r;
endmodule : tcp_host_end

// file: tcp_link_monitor.sv
/*
 * link monitor: pin-level checks on both ends of the control port.
 * assumes host serial half period of 8 system cycles.
 */
`timescale 1ns/1ps
module tcp_link_monitor #(
	parameter int RUN_HOLD = 1,
	parameter int ACC_WAIT = 30
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic rst_n,
	input wire logic spi_sel,
	input wire logic style_sel,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic strb_a_n,
	input wire logic strb_b,
	input wire logic irq_n,
	input wire logic hd_oe,
	input wire logic dd_oe
);
	// ==========================================================
	// helper counters
	logic [15:0] low_r;
	logic [15:0] up_r;
	logic [5:0] edges_r;
	logic sclk_r;
	wire sclk_up = sclk && !sclk_r;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_sys_i) begin
		sclk_r <= sclk;
		low_r <= (rst_i || rst_n) ? 16'h0000 : low_r + 16'h0001;
		up_r <= (rst_i || !rst_n) ? 16'h0000 : up_r + {15'h0000, ~&up_r};
		edges_r <= (rst_i || cs_n) ? 6'h00 : edges_r + {5'h00, sclk_up};
	end
	// ==========================================================
	// serial frame
	sequence s_frame_open;
		$fell(cs_n) && spi_sel;
	endsequence
	sequence s_read_strobe;
		!spi_sel && !cs_n && !strb_a_n && (style_sel || strb_b);
	endsequence
	a_frame_quiet: assert property (s_frame_open |-> !sclk [*8])
		else $error("sclk moved too early in frame");
	a_frame_edges: assert property ($rose(cs_n) && spi_sel |->
		edges_r == 6'h18) else $error("frame edge count off");
	a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*8])
		else $error("chip select gap too short");
	a_sdi_steady: assert property ($rose(sclk) |-> $stable(sdi) [*8])
		else $error("sdi moved while sclk high");
	a_sdo_on_fall: assert property (
		spi_sel && !cs_n && $changed(sdo) |-> !sclk)
		else $error("sdo moved while sclk high");
	// ==========================================================
	// parallel bus
	a_bus_clash: assert property (!(hd_oe && dd_oe))
		else $error("both ends drive data bus");
	a_read_float: assert property (s_read_strobe |-> !hd_oe)
		else $error("host drives bus during read");
	a_dev_drive: assert property ($rose(dd_oe) |->
		!strb_a_n && !cs_n && !spi_sel && (style_sel || strb_b))
		else $error("device drives bus outside read");
	// ==========================================================
	// resets
	a_reset_hold: assert property ($rose(rst_n) |->
		low_r >= RUN_HOLD) else $error("reset pulse too short");
	a_access_wait: assert property ($fell(cs_n) |->
		up_r >= ACC_WAIT) else $error("access too soon after reset");
	a_irq_reset: assert property ($fell(rst_n) |-> ##[1:4] irq_n)
		else $error("irq not released by reset");
endmodule : tcp_link_monitor

// file: tcp_tb_top.sv
/*
 * testbench: apb master on the host end, device end across the link.
 * assumes shortened reset, wait and timer counts and a lengthened busy count.
 */
`timescale 1ns/1ps
module tcp_tb_top;
	import tcp_pkg::*;
	localparam int SEC_N = 300;
	// shortened reset and wait counts; long busy so the host sees it
	localparam int RST_N = 20;
	localparam int RUN_N = 1;
	localparam int WAIT_N = 30;
	localparam int IND_N = 200;
	logic clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [47:0] mod_irq;
	logic [1:0] rx_data, tx_data, rx_path, tx_path, tx_oe;
	int n_errors, total_checks;
	tcp_link_if lnk();
	tcp_host_end #(.RST_HOLD(RST_N), .RUN_HOLD(RUN_N), .ACC_WAIT(WAIT_N))
	u_tcp_host_end (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .lnk(lnk));
	tcp_dev_end #(.SEC_CYCLES(SEC_N), .IND_CYCLES(IND_N)) u_tcp_dev_end (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .lnk(lnk),
		.mod_irq_i(mod_irq), .rx_data_i(rx_data), .tx_data_i(tx_data),
		.rx_path_o(rx_path), .tx_path_o(tx_path), .tx_path_oe_o(tx_oe));
	tcp_link_monitor #(.RUN_HOLD(RUN_N), .ACC_WAIT(WAIT_N))
	u_tcp_link_monitor (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .rst_n(lnk.rst_n),
		.spi_sel(lnk.spi_sel), .style_sel(lnk.style_sel),
		.cs_n(lnk.cs_n), .sclk(lnk.sclk), .sdi(lnk.sdi), .sdo(lnk.sdo),
		.strb_a_n(lnk.strb_a_n), .strb_b(lnk.strb_b),
		.irq_n(lnk.irq_n), .hd_oe(lnk.hd_oe), .dd_oe(lnk.dd_oe));
	// ==========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [7:0] exp,
		input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		// no cycle count assumed: pready ends this wait, and only the watchdog bounds it
		do begin
			@(posedge clk_sys_i);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys_i);
	endtask : apb
	// poll until the host is idle; hands back the last status word
	task automatic wait_idle(output logic [31:0] r);
		logic e;
		@(posedge clk_sys_i);
		do begin
			apb(1'b0, APB_STAT, 32'h0, r, e);
		end while (r[0] !== 1'b0);
	endtask : wait_idle
	task automatic dev(input logic rd, input logic [10:0] a,
		input logic [7:0] wd, output logic [7:0] q);
		logic [31:0] r;
		logic e;
		apb(1'b1, APB_CMD, {8'h00, wd, 3'h0, rd, 1'b0, a}, r, e);
		wait_idle(r);
		q = r[15:8];
	endtask : dev
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		logic [7:0] q;
		dev(1'b0, a, d, q);
	endtask : wr
	task automatic rdchk(input string nm, input logic [10:0] a,
		input logic [7:0] exp);
		logic [7:0] q;
		dev(1'b1, a, 8'h00, q);
		chk(nm, exp, q);
	endtask : rdchk
	task automatic cfg(input logic spi, input logic sty);
		logic [31:0] r;
		logic e;
		apb(1'b1, APB_CFG, {30'h0, sty, spi}, r, e);
	endtask : cfg
	task automatic ind_wait;
		logic [7:0] q;
		do begin
			dev(1'b1, 11'h0C8, 8'h00, q);
		end while (q[0] !== 1'b0);
	endtask : ind_wait
	// ==========================================================
	// scenarios
	task automatic t_spi;
		cfg(1'b1, 1'b0);
		wr(11'h022, 8'h10);
		rdchk("tx cfg spi", 11'h022, 8'h10);
		chk("tx oe", 8'h02, {6'h00, tx_oe});
		chk("tx path", 8'h02, {6'h00, tx_path});
		wr(11'h128, 8'h10);
		chk("rx path", 8'h01, {6'h00, rx_path});
	endtask : t_spi
	task automatic t_par;
		logic [7:0] v;
		for (int s = 0; s < 2; s++) begin
			v = s ? 8'h00 : 8'h10;
			cfg(1'b0, s[0]);
			wr(11'h122, v);
			rdchk("tx cfg par", 11'h122, v);
			chk("tx oe par", {7'h00, ~v[4]}, {7'h00, tx_oe[1]});
		end
	endtask : t_par
	task automatic t_soft;
		wr(11'h020, 8'h0B);
		rdchk("line std", 11'h020, 8'h0B);
		rdchk("tx cfg soft", 11'h022, 8'h00);
		chk("rx path soft", 8'h03, {6'h00, rx_path});
	endtask : t_soft
	task automatic t_irq;
		mod_irq <= 48'h0002_0000_0000;
		repeat (3) @(posedge clk_sys_i);
		chk("irq low", 8'h00, {7'h00, lnk.irq_n});
		rdchk("link src", 11'h009, 8'h02);
		rdchk("module one", 11'h141, 8'h02);
		mod_irq <= 48'h0;
		repeat (3) @(posedge clk_sys_i);
		chk("irq high", 8'h01, {7'h00, lnk.irq_n});
	endtask : t_irq
	task automatic t_timer;
		int n;
		n = 0;
		wr(11'h00A, 8'h01);
		while (lnk.irq_n !== 1'b0 && n < 2 * SEC_N) begin
			@(posedge clk_sys_i);
			n++;
		end
		chk("timer irq", 8'h00, {7'h00, lnk.irq_n});
		rdchk("timer flag", 11'h00B, 8'h01);
		wr(11'h00A, 8'h00);
		repeat (3) @(posedge clk_sys_i);
		chk("timer irq off", 8'h01, {7'h00, lnk.irq_n});
	endtask : t_timer
	task automatic t_ind;
		rdchk("busy idle", 11'h0C8, 8'h00);
		wr(11'h0CA, 8'hA5);
		wr(11'h0C9, 8'h05);
		rdchk("busy set", 11'h0C8, 8'h01);
		wr(11'h0C9, 8'h86);
		ind_wait();
		rdchk("data kept", 11'h0CA, 8'hA5);
		wr(11'h0CA, 8'h00);
		wr(11'h0C9, 8'h85);
		ind_wait();
		rdchk("ind read", 11'h0CA, 8'hA5);
	endtask : t_ind
	task automatic t_hw;
		logic [31:0] r;
		logic e;
		apb(1'b1, 8'h10, 32'h0, r, e);
		chk("slverr", 8'h01, {7'h00, e});
		apb(1'b1, APB_CTRL, 32'h1, r, e);
		wait_idle(r);
		rdchk("line std hw", 11'h020, 8'h00);
	endtask : t_hw
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// ==========================================================
	// clock, watchdog, main sequence
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		n_errors++;
		finish_test();
	end
	initial begin
		logic [31:0] r;
		rst_i = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mod_irq = 48'h0;
		rx_data = 2'b11;
		tx_data = 2'b11;
		repeat (4) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		wait_idle(r);
		chk("irq idle", 8'h01, {7'h00, lnk.irq_n});
		t_spi();
		t_par();
		t_soft();
		t_irq();
		t_timer();
		t_ind();
		t_hw();
		finish_test();
	end
endmodule : tcp_tb_top
